// *** logic/io_line_pkg.sv ***
// Package with constants and types for the external I/O line block.
package io_line_pkg;
   // Setup flag bit positions.
   localparam int DIR_OUT_BIT = 0;
   localparam int POL_INV_BIT = 1;
   // Mode byte fields: input action low nibble, output behaviour high.
   localparam int IN_FIELD_LSB = 0;
   localparam int OUT_FIELD_LSB = 4;
   // Input action codes.
   localparam logic [3:0] input_action_none = 4'h0;
   localparam logic [3:0] input_action_halt = 4'h1;
   localparam logic [3:0] input_action_windings_off = 4'h2;
   localparam logic [3:0] input_action_relative_move = 4'h3;
   localparam logic [3:0] input_action_homing = 4'h4;
   localparam logic [3:0] input_action_raise_alarm = 4'h5;
   // Output behaviour codes, as held in the high nibble.
   localparam logic [3:0] output_always_inactive = 4'h0;
   localparam logic [3:0] output_always_active = 4'h1;
   localparam logic [3:0] output_follows_motion = 4'h2;
   localparam logic [3:0] output_follows_alarm = 4'h3;
   localparam logic [3:0] output_follows_winding_power = 4'h4;
   // Values after reset.
   localparam logic [7:0] SETUP_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   // Read-settings command and answer layout.
   localparam logic [31:0] READ_SETTINGS_CMD = 32'h6f696567;
   localparam int CMD_BYTES = 4;
   localparam int ANSWER_BYTES = 18;
   localparam logic [4:0] SETUP_IDX = 5'h04;
   localparam logic [4:0] MODE_IDX = 5'h05;
   localparam logic [4:0] SUM_LO_IDX = 5'h10;
   localparam logic [4:0] LAST_IDX = 5'h11;
   localparam logic [4:0] IDX_RESET = 5'h00;

   // Motor state seen by the output behaviours.
   typedef struct packed {
      logic moving;
      logic alarm;
      logic powered;
   } motor_state_t;

   // One-cycle action requests toward the motion core.
   typedef struct packed {
      logic halt;
      logic windings_off;
      logic relative_move;
      logic homing;
      logic raise_alarm;
   } action_req_t;

   // Answer sequencer states, one-hot.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } answer_state_t;
endpackage

// *** logic/line_event_detect.sv ***
// Samples the external line and finds entries into the active state.
`timescale 1ns/1ps
module line_event_detect (
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // Line level and polarity.
   input wire logic line_level,
   input wire logic invert,
   // Results.
   output logic active,
   output logic enter_active
);
   // Registered active level and its previous value.
   logic active_r;
   logic prev_r;

   // Sample the line once per enabled cycle, folding in the polarity.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         active_r <= 1'b0;
         prev_r <= 1'b0;
      end else if (ce) begin
         active_r <= line_level ^ invert;
         prev_r <= active_r;
      end
   end

   // Only the transition counts, so a held level fires once.
   assign active = active_r;
   assign enter_active = ce && active_r && !prev_r;
endmodule // line_event_detect

// *** logic/external_io_line.sv ***
// External I/O line: direction, polarity, actions, output, settings read.
// Notes on behaviour
// - Direction bit selects output or input.
// - Invert bit swaps active level and edge.
// - Low mode nibble selects input action.
// - Codes 0/1/4: nothing, halt, homing.
// - Code 2 powers off the windings.
// - Code 3 repeats last relative move.
// - Code 5 raises the alarm.
// - High mode nibble selects output behaviour.
// - Output code 0: always inactive.
// - Output code 1: always active.
// - Output code 2: active while moving.
// - Output code 3: active during alarm.
// - Output code 4: active while windings powered.
// - Read command answers 18 settings bytes.
`timescale 1ns/1ps
module external_io_line (
   // Clock, reset and enable.
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // Settings write port.
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_setup,
   input wire logic [7:0] cfg_mode,
   // Request byte stream from the host.
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   // Answer byte stream to the host.
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready,
   // Motor state and action requests.
   input io_line_pkg::motor_state_t motor_state,
   output io_line_pkg::action_req_t action_req,
   // External line pin.
   input wire logic line_in,
   output logic line_out,
   output logic line_oe_n
);
   import io_line_pkg::*;

   // All checks below share the core clock and stand down during reset.
   default clocking chk_cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   logic [7:0] setup_r; // Setup flags register.
   logic [7:0] mode_r; // Mode flags register.
   logic [7:0] snap_setup_r; // Setup copy held for one answer.
   logic [7:0] snap_mode_r; // Mode copy held for one answer.
   logic [31:0] cmd_r; // Request bytes gathered so far.
   logic [1:0] cmd_cnt_r; // Count of request bytes gathered.
   logic [4:0] idx_r; // Index of the answer byte on offer.
   answer_state_t state_r; // Answer sequencer state.
   action_req_t act_nxt; // Decoded action for this cycle.
   logic line_active; // Line in its active state.
   logic line_enter; // Line just became active.
   logic cmd_hit; // A full read-settings request arrived.
   logic tx_take; // The host takes the answer byte on offer.
   logic [3:0] in_sel; // Input action selector.
   logic [3:0] out_sel; // Output behaviour selector.
   logic drive_active; // Output wants the active state.

   // Builds one answer byte; the checksum is the sum of bytes 4 to 15.
   function automatic logic [7:0] answer_byte(input logic [4:0] idx,
      input logic [7:0] s, input logic [7:0] m);
      logic [15:0] sum;
      sum = {8'h00, s} + {8'h00, m};
      if (idx < 5'(CMD_BYTES)) begin
         answer_byte = READ_SETTINGS_CMD[8*idx[1:0] +: 8];
      end else if (idx == SETUP_IDX) begin
         answer_byte = s;
      end else if (idx == MODE_IDX) begin
         answer_byte = m;
      end else if (idx == SUM_LO_IDX) begin
         answer_byte = sum[7:0];
      end else if (idx == LAST_IDX) begin
         answer_byte = sum[15:8];
      end else begin
         answer_byte = 8'h00;
      end
   endfunction

   // Edge and level detection of the incoming line.
   line_event_detect u_detect (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .line_level(line_in),
      .invert(setup_r[POL_INV_BIT]),
      .active(line_active),
      .enter_active(line_enter)
   );

   // Settings registers are loaded from the write port.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         setup_r <= SETUP_RESET;
         mode_r <= MODE_RESET;
      end else if (ce && cfg_wr) begin
         setup_r <= cfg_setup;
         mode_r <= cfg_mode;
      end
   end

   assign in_sel = mode_r[IN_FIELD_LSB +: 4];
   assign out_sel = mode_r[OUT_FIELD_LSB +: 4];

   // Decode the input action; nothing fires while the line is an output.
   always_comb begin
      act_nxt = '0;
      if (line_enter && !setup_r[DIR_OUT_BIT]) begin
         case (in_sel)
            input_action_none: act_nxt = '0;
            input_action_halt: act_nxt.halt = 1'b1;
            input_action_windings_off: act_nxt.windings_off = 1'b1;
            input_action_relative_move: act_nxt.relative_move = 1'b1;
            input_action_homing: act_nxt.homing = 1'b1;
            input_action_raise_alarm: act_nxt.raise_alarm = 1'b1;
            default: act_nxt = '0;
         endcase
      end
   end

   // Action requests are one-cycle pulses from a register.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         action_req <= '0;
      end else if (ce) begin
         action_req <= act_nxt;
      end
   end

   // Choose the logical level the output behaviour asks for.
   always_comb begin
      case (out_sel)
         output_always_inactive: drive_active = 1'b0;
         output_always_active: drive_active = 1'b1;
         output_follows_motion: drive_active = motor_state.moving;
         output_follows_alarm: drive_active = motor_state.alarm;
         output_follows_winding_power: begin
            drive_active = motor_state.powered;
         end
         default: drive_active = 1'b0;
      endcase
   end

   // Pin driver: polarity applied, enable low while driving.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         line_out <= 1'b0;
         line_oe_n <= 1'b1;
      end else if (ce) begin
         line_out <= drive_active ^ setup_r[POL_INV_BIT];
         line_oe_n <= !setup_r[DIR_OUT_BIT];
      end
   end

   // A request completes on its fourth byte, least significant first.
   assign cmd_hit = ce && rx_valid && cmd_cnt_r == 2'(CMD_BYTES - 1) &&
      {rx_byte, cmd_r[31:8]} == READ_SETTINGS_CMD;
   assign tx_take = ce && tx_valid && tx_ready;

   // Gather request bytes; bytes arriving during an answer are dropped.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmd_r <= 32'h00000000;
         cmd_cnt_r <= 2'h0;
      end else if (ce && rx_valid && state_r == ST_IDLE) begin
         cmd_r <= {rx_byte, cmd_r[31:8]};
         cmd_cnt_r <= cmd_cnt_r + 2'h1;
      end
   end

   // Answer sequencer: offers 18 bytes, each held until taken.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         idx_r <= IDX_RESET;
         tx_valid <= 1'b0;
         tx_byte <= 8'h00;
         snap_setup_r <= SETUP_RESET;
         snap_mode_r <= MODE_RESET;
      end else if (ce) begin
         case (state_r)
            ST_IDLE: begin
               if (cmd_hit) begin
                  state_r <= ST_SEND;
                  idx_r <= IDX_RESET;
                  tx_valid <= 1'b1;
                  tx_byte <= answer_byte(IDX_RESET, setup_r, mode_r);
                  snap_setup_r <= setup_r;
                  snap_mode_r <= mode_r;
               end
            end
            ST_SEND: begin
               if (tx_take && idx_r == LAST_IDX) begin
                  state_r <= ST_IDLE;
                  tx_valid <= 1'b0;
                  tx_byte <= 8'h00;
               end else if (tx_take) begin
                  idx_r <= idx_r + 5'h01;
                  tx_byte <= answer_byte(idx_r + 5'h01, snap_setup_r,
                     snap_mode_r);
               end
            end
            default: begin
               state_r <= ST_IDLE;
               tx_valid <= 1'b0;
            end
         endcase
      end
   end

   // Checks on the line, actions and answer.
   a_halt_pulse: assert property (
      line_enter && !setup_r[DIR_OUT_BIT] && in_sel == input_action_halt
      |=> action_req.halt)
      else $error("halt not issued on line entry");
   a_windings_off: assert property (
      line_enter && !setup_r[DIR_OUT_BIT] &&
      in_sel == input_action_windings_off |=> action_req.windings_off)
      else $error("windings off not issued");
   a_relmove_alarm: assert property (
      line_enter && !setup_r[DIR_OUT_BIT] &&
      in_sel == input_action_raise_alarm
      |=> action_req.raise_alarm && !action_req.relative_move)
      else $error("alarm request wrong");
   a_relmove_pulse: assert property (
      line_enter && !setup_r[DIR_OUT_BIT] &&
      in_sel == input_action_relative_move |=> action_req.relative_move)
      else $error("relative move not issued");
   a_homing_pulse: assert property (
      line_enter && !setup_r[DIR_OUT_BIT] && in_sel == input_action_homing
      |=> action_req.homing)
      else $error("homing not issued");
   a_single_action: assert property (
      ce && action_req != '0 ##1 ce |-> action_req == '0)
      else $error("action repeated while line held");
   a_no_act_out: assert property (
      ce && setup_r[DIR_OUT_BIT] && $stable(setup_r)
      |=> action_req == '0)
      else $error("action while line is output");
   a_dir_drive: assert property (
      ce |=> line_oe_n == !$past(setup_r[DIR_OUT_BIT]))
      else $error("enable does not follow direction");
   a_active_level: assert property (
      ce |=> line_active ==
      ($past(line_in) ^ $past(setup_r[POL_INV_BIT])))
      else $error("active level ignores polarity");
   a_out_motion: assert property (
      ce && out_sel == output_follows_motion |=>
      line_out == ($past(motor_state.moving) ^
      $past(setup_r[POL_INV_BIT])))
      else $error("output does not follow motion");
   a_out_const: assert property (
      ce && out_sel == output_always_active && !setup_r[POL_INV_BIT]
      |=> line_out)
      else $error("always-active output low");
   a_answer_head: assert property (
      cmd_hit && state_r == ST_IDLE |=> tx_valid && tx_byte == 8'h67 &&
      idx_r == IDX_RESET)
      else $error("answer does not start with command echo");
   a_answer_end: assert property (
      tx_take && idx_r == LAST_IDX |=> !tx_valid && state_r == ST_IDLE)
      else $error("answer length wrong");

   c_answer: cover property (@(posedge core_clk) disable iff (rst)
      tx_take && idx_r == LAST_IDX);
   c_homing: cover property (@(posedge core_clk) disable iff (rst)
      action_req.homing);
   c_relmove: cover property (@(posedge core_clk) disable iff (rst)
      action_req.relative_move);
   c_drive_out: cover property (@(posedge core_clk) disable iff (rst)
      !line_oe_n && line_out);
endmodule // external_io_line

// *** verif/line_equipment.sv ***
// Model of the external equipment wired to the I/O line pin.
`timescale 1ns/1ps
module line_equipment (
   // Clock for the floating-line pattern.
   input wire logic core_clk,
   // Equipment drive request.
   input wire logic drive_en,
   input wire logic drive_level,
   // Device side of the pin.
   input wire logic line_out,
   input wire logic line_oe_n,
   // Resolved wire level.
   output logic line_wire
);
   logic float_r = 1'b0; // Pattern shown on an undriven wire.

   // The line has no pull, so a released wire toggles every cycle.
   always_ff @(posedge core_clk) begin
      float_r <= ~float_r;
   end

   // The device owns the wire while its enable is low.
   always_comb begin
      if (!line_oe_n) begin
         line_wire = line_out;
      end else if (drive_en) begin
         line_wire = drive_level;
      end else begin
         line_wire = float_r;
      end
   end
endmodule // line_equipment

// *** verif/test_external_io_line.sv ***
// Self-checking bench for the external I/O line block.
`timescale 1ns/1ps
module test_external_io_line;
   import io_line_pkg::*;
   logic core_clk = 1'b0; // Core clock, 200 MHz.
   logic rst = 1'b1; // Reset, held at the start.
   logic ce = 1'b1; // Clock enable, high except while test_freeze holds it low.
   logic cfg_wr = 1'b0; // Settings write strobe.
   logic [7:0] cfg_setup = 8'h00; // Setup flags to write.
   logic [7:0] cfg_mode = 8'h00; // Mode flags to write.
   logic rx_valid = 1'b0; // Request byte valid.
   logic [7:0] rx_byte = 8'h00; // Request byte.
   logic tx_ready = 1'b0; // Host takes answer bytes.
   logic tx_valid; // Answer byte valid.
   logic [7:0] tx_byte; // Answer byte.
   motor_state_t motor_state = '0; // Motor state levels.
   action_req_t action_req; // Action pulses.
   logic drive_en = 1'b1; // Equipment drives the line.
   logic drive_level = 1'b0; // Level driven by the equipment.
   logic line_wire; // Resolved pin level.
   logic line_out; // Device pin level.
   logic line_oe_n; // Device pin enable.
   int error_cnt = 0; // Mismatches seen.
   int compares = 0; // Comparisons made.

   // Clock generator, 5 ns period.
   always #2.5 core_clk = ~core_clk;

   external_io_line i_dut (.core_clk, .rst, .ce, .cfg_wr, .cfg_setup,
      .cfg_mode, .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready,
      .motor_state, .action_req, .line_in(line_wire), .line_out,
      .line_oe_n);
   line_equipment i_equip (.core_clk, .drive_en, .drive_level, .line_out,
      .line_oe_n, .line_wire);

   // Compares one value and reports a mismatch.
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Writes both settings registers and waits until the pin follows.
   task automatic wr_cfg(input logic [7:0] s, input logic [7:0] m);
      @(negedge core_clk);
      cfg_setup = s;
      cfg_mode = m;
      cfg_wr = 1'b1;
      @(negedge core_clk);
      cfg_wr = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask

   // Sends four request bytes, lowest byte first, back to back.
   task automatic send_word(input logic [31:0] w);
      for (int i = 0; i < 4; i++) begin
         rx_valid = 1'b1;
         rx_byte = w[8*i +: 8];
         @(negedge core_clk);
      end
      rx_valid = 1'b0;
   endtask

   // Pin state and answer stream right after reset.
   task automatic test_reset();
      chk("line_oe_n", 8'h01, 8'(line_oe_n));
      chk("line_out", 8'h00, 8'(line_out));
      chk("tx_valid", 8'h00, 8'(tx_valid));
      $display("test_reset done");
   endtask

   // Every output behaviour, both polarities, every motor state.
   task automatic test_outputs();
      logic act;
      drive_en = 1'b0;
      for (int c = 0; c < 5; c++) begin
         for (int v = 0; v < 16; v++) begin
            motor_state = motor_state_t'(v[2:0]);
            wr_cfg({6'h00, v[3], 1'b1}, {c[3:0], input_action_none});
            case (c)
               1: act = 1'b1;
               2: act = motor_state.moving;
               3: act = motor_state.alarm;
               4: act = motor_state.powered;
               default: act = 1'b0;
            endcase
            chk("oe_n", 8'h00, 8'(line_oe_n));
            chk("out", 8'(act ^ v[3]), 8'(line_out));
         end
      end
      $display("test_outputs done");
   endtask

   // Every input action code, plus one unknown, in both polarities.
   task automatic test_actions();
      action_req_t exp;
      logic inv;
      drive_en = 1'b1;
      for (int c = 0; c < 14; c++) begin
         inv = (c >= 7);
         exp = '0;
         exp.halt = (c % 7 == 1);
         exp.windings_off = (c % 7 == 2);
         exp.relative_move = (c % 7 == 3);
         exp.homing = (c % 7 == 4);
         exp.raise_alarm = (c % 7 == 5);
         drive_level = inv;
         wr_cfg({6'h00, inv, 1'b0}, {4'h0, 4'(c % 7)});
         chk("oe_n", 8'h01, 8'(line_oe_n));
         chk("idle", 8'h00, 8'(action_req));
         drive_level = ~inv;
         repeat (2) @(negedge core_clk);
         chk("act", 8'(exp), 8'(action_req));
         repeat (3) @(negedge core_clk);
         chk("held", 8'h00, 8'(action_req));
         drive_level = inv;
         repeat (2) @(negedge core_clk);
         chk("leave", 8'h00, 8'(action_req));
      end
      $display("test_actions done");
   endtask

   // A wrong request is dropped; a read request returns the settings.
   task automatic test_read();
      logic [7:0] ans [18];
      int n;
      ans = '{default: 8'h00};
      ans[0] = 8'h67;
      ans[1] = 8'h65;
      ans[2] = 8'h69;
      ans[3] = 8'h6f;
      ans[4] = 8'h03;
      ans[5] = 8'h35;
      {ans[17], ans[16]} = 16'(ans[4]) + 16'(ans[5]);
      wr_cfg(ans[4], ans[5]);
      send_word(32'h00696567);
      repeat (3) @(negedge core_clk);
      chk("drop", 8'h00, 8'(tx_valid));
      send_word(READ_SETTINGS_CMD);
      n = 0;
      while (tx_valid !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      // The host stalls; a new request and a settings write arrive meanwhile.
      // Neither may disturb the answer, whose first byte must stand.
      send_word(READ_SETTINGS_CMD);
      wr_cfg(8'h00, 8'h00);
      tx_ready = 1'b1;
      for (int i = 0; i < 18; i++) begin
         chk("answer", ans[i], tx_byte);
         @(negedge core_clk);
      end
      tx_ready = 1'b0;
      chk("end", 8'h00, 8'(tx_valid));
      $display("test_read done");
   endtask

   // A low clock enable freezes sampling; the event fires once on release.
   task automatic test_freeze();
      action_req_t exp;
      exp = '0;
      exp.halt = 1'b1;
      drive_en = 1'b1;
      drive_level = 1'b0;
      wr_cfg(8'h00, {4'h0, input_action_halt});
      ce = 1'b0;
      drive_level = 1'b1;
      repeat (4) @(negedge core_clk);
      chk("frozen", 8'h00, 8'(action_req));
      ce = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("thaw", 8'(exp), 8'(action_req));
      @(negedge core_clk);
      chk("once", 8'h00, 8'(action_req));
      drive_level = 1'b0;
      repeat (2) @(negedge core_clk);
      $display("test_freeze done");
   endtask

   // A reset in mid-answer restores the settings and drops the answer.
   task automatic test_mid_reset();
      logic [7:0] e;
      wr_cfg(8'h01, {output_always_active, input_action_none});
      chk("pre_out", 8'h01, 8'(line_out));
      send_word(READ_SETTINGS_CMD);
      rst = 1'b1;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("rst_oe_n", 8'h01, 8'(line_oe_n));
      chk("rst_out", 8'h00, 8'(line_out));
      chk("rst_tx", 8'h00, 8'(tx_valid));
      chk("rst_act", 8'h00, 8'(action_req));
      send_word(READ_SETTINGS_CMD);
      tx_ready = 1'b1;
      for (int i = 0; i < 18; i++) begin
         e = (i < 4) ? READ_SETTINGS_CMD[8*i +: 8] : 8'h00;
         chk("rst_answer", e, tx_byte);
         @(negedge core_clk);
      end
      tx_ready = 1'b0;
      chk("rst_end", 8'h00, 8'(tx_valid));
      $display("test_mid_reset done");
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Main sequence: reset for 16 cycles, then the tests.
   initial begin
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      repeat (2) @(negedge core_clk);
      test_reset();
      test_outputs();
      test_actions();
      test_freeze();
      test_read();
      test_mid_reset();
      wrap_up();
   end

   // Watchdog, well beyond the roughly 700 cycles the tests need.
   initial begin
      #50000;
      error_cnt++;
      wrap_up();
   end
endmodule // test_external_io_line
